//--- tyg_yellow_gen.sv
// Transmit yellow alarm generator with one-second rule and APB registers
`timescale 1ns/10ps
// Notes on behaviour
// - One-second behaviour acts only while enforce bit 7 is one.
// - Writing duration bit one starts alarm, zero stops it, per format.
// - Select 00 sends no yellow alarm in any framing mode.
// - Select 01 in SF or N forces DS0 bit 2 to zero.
// - Select 01 in T1DM clears the Y-bit of the SYNC byte.
// - Select 01 in ESF sends eight ones then eight zeros on data link.
// - Short duration pulse in ESF with select 01 or 11 gives exactly 255 patterns.
// - Duration bit held past 255 patterns keeps alarm until it drops.
// - A new pulse during alarm restarts the pattern counter.
// - At least one second between alarm end and next start; requests wait.
// - J1 selection in SF sends a one in Fs bit of frame 12.
// - J1 selection in ESF follows the duration bit, stopping at the next pattern boundary.
// - Select 11 in SF, N or T1DM uses the select 01 format.
// - Select 11 in ESF uses 01 duration with sixteen-ones patterns.
module tyg_yellow_gen
    import tyg_pkg::*;
#(
    parameter int unsigned GAP_CYCLES = TYG_GAP_CYCLES
) (
    input wire logic clk_sys_in,
    input wire logic rstn_in,
    input wire tyg_apb_req_t apb_in,
    output tyg_apb_rsp_t apb_out,
    input wire logic dl_bit_req_in,
    output tyg_alarm_t alarm_out
);
    localparam logic [TYG_GAP_W-1:0] GAP_LAST = TYG_GAP_W'(GAP_CYCLES - 1);

    tyg_state_t r;
    tyg_state_t n;
    logic access;
    logic wr;
    logic ctl_rise;
    logic pat_done;
    logic enable;
    logic esf;
    logic burst;
    logic stop;
    logic [1:0] sel;

    always_comb begin
        n = r;
        access = apb_in.psel & apb_in.penable;
        wr = access & apb_in.pwrite & r.rsp.pready;
        ctl_rise = 1'b0;
        stop = 1'b0;

        // One wait state keeps read data and pready straight from flops
        n.rsp.pready = access & ~r.rsp.pready;
        n.rsp.prdata = 32'h0000_0000;
        n.rsp.pslverr = 1'b0;
        if (access && !r.rsp.pready) begin
            case (apb_in.paddr)
                TYG_AGC_ADDR: n.rsp.prdata = {24'h00_0000, r.agc};
                TYG_STAT_ADDR: n.rsp.prdata = {16'h0000, r.count, 4'h0, r.pend, r.fsm};
                TYG_MODE_ADDR: n.rsp.prdata = {30'h0000_0000, r.mode};
                default: n.rsp.pslverr = 1'b1;
            endcase
        end

        if (wr && apb_in.paddr == TYG_AGC_ADDR) begin
            n.agc = apb_in.pwdata[7:0];
            ctl_rise = apb_in.pwdata[TYG_CTL_BIT] & ~r.agc[TYG_CTL_BIT];
        end
        if (wr && apb_in.paddr == TYG_MODE_ADDR) begin
            n.mode = apb_in.pwdata[1:0];
        end

        sel = n.agc[TYG_SEL_LSB+1:TYG_SEL_LSB];
        enable = n.agc[TYG_ENF_BIT] && sel != TYG_SEL_OFF;
        esf = n.mode == TYG_MODE_ESF;
        burst = esf && sel != TYG_SEL_J1;
        pat_done = dl_bit_req_in && r.idx == TYG_PAT_LAST;

        // Pending request survives the gap so a write there is not lost
        if (ctl_rise) begin
            n.pend = 1'b1;
        end

        case (r.fsm)
            TYG_IDLE: begin
                if (!enable) begin
                    n.pend = 1'b0;
                end else if (n.pend && (burst || n.agc[TYG_CTL_BIT])) begin
                    n.fsm = TYG_SEND;
                    n.pend = 1'b0;
                    n.count = 8'h00;
                    n.idx = 4'h0;
                end
            end
            TYG_SEND: begin
                if (!enable) begin
                    stop = 1'b1;
                end else if (esf) begin
                    if (dl_bit_req_in) begin
                        n.idx = r.idx + 4'h1;
                    end
                    if (pat_done && r.count != TYG_PATTERNS) begin
                        n.count = r.count + 8'h01;
                    end
                    // ESF stops only on a pattern boundary
                    if (pat_done && !n.agc[TYG_CTL_BIT]) begin
                        if (!burst) begin
                            stop = 1'b1;
                        end else if (n.count == TYG_PATTERNS) begin
                            stop = 1'b1;
                        end
                    end
                    if (ctl_rise) begin
                        n.count = 8'h00;
                        n.pend = 1'b0;
                    end
                end else begin
                    stop = !n.agc[TYG_CTL_BIT];
                    n.pend = 1'b0;
                end
                if (stop) begin
                    n.fsm = TYG_GAP;
                    n.gap_cnt = '0;
                end
            end
            TYG_GAP: begin
                n.gap_cnt = r.gap_cnt + 1'b1;
                if (r.gap_cnt >= GAP_LAST) begin
                    n.fsm = TYG_IDLE;
                end
            end
            default: begin
                n.fsm = TYG_IDLE;
            end
        endcase

        n.alarm.active = n.fsm == TYG_SEND;
        n.alarm.ds0_force = n.alarm.active && (sel == TYG_SEL_STD || sel == TYG_SEL_J1ESF)
            && (n.mode == TYG_MODE_SF || n.mode == TYG_MODE_N);
        n.alarm.ybit_clear = n.alarm.active && sel != TYG_SEL_OFF
            && n.mode == TYG_MODE_T1DM;
        n.alarm.fs12_one = n.alarm.active && sel == TYG_SEL_J1
            && n.mode == TYG_MODE_SF;
        n.alarm.dl_valid = n.alarm.active && esf;
        // Sixteen ones for the J1 ESF format, else ones then zeros
        n.alarm.dl_bit = n.alarm.dl_valid
            && (sel == TYG_SEL_J1ESF || n.idx < TYG_PAT_HALF);
    end

    always_ff @(posedge clk_sys_in or negedge rstn_in) begin
        if (!rstn_in) begin
            r <= '{
                agc: TYG_AGC_RESET,
                mode: TYG_MODE_RESET,
                fsm: TYG_IDLE,
                pend: 1'b0,
                count: 8'h00,
                idx: 4'h0,
                gap_cnt: '0,
                rsp: '0,
                alarm: '0
            };
        end else begin
            r <= n;
        end
    end

    assign apb_out = r.rsp;
    assign alarm_out = r.alarm;

    // Checks

    logic [1:0] r_sel;
    logic r_enf;
    logic r_ctl;
    assign r_sel = r.agc[TYG_SEL_LSB+1:TYG_SEL_LSB];
    assign r_enf = r.agc[TYG_ENF_BIT];
    assign r_ctl = r.agc[TYG_CTL_BIT];

    default clocking cb @(posedge clk_sys_in);
    endclocking
    default disable iff (!rstn_in);

    sequence alarm_ends;
        $fell(alarm_out.active);
    endsequence

    sequence quiet_8;
        !alarm_out.active [*8];
    endsequence

    sequence ctl_rises_in_send;
        r.fsm == TYG_SEND && ctl_rise && esf;
    endsequence

    sequence pattern_end;
        r.fsm == TYG_SEND && esf && enable && pat_done;
    endsequence

    sequence pattern_mid;
        r.fsm == TYG_SEND && esf && enable && !pat_done;
    endsequence

    chk_rule_gate: assert property (!r_enf |-> !alarm_out.active)
        else $error("alarm active with rule not enforced");

    chk_sel_off: assert property (r_sel == TYG_SEL_OFF |->
        !(alarm_out.ds0_force | alarm_out.ybit_clear | alarm_out.fs12_one
        | alarm_out.dl_valid))
        else $error("alarm output with select off");

    chk_ds0_force: assert property (alarm_out.active && r_sel[0]
        && (r.mode == TYG_MODE_SF || r.mode == TYG_MODE_N) |-> alarm_out.ds0_force)
        else $error("DS0 bit force missing");

    chk_ybit_clear: assert property (alarm_out.active && r.mode == TYG_MODE_T1DM
        |-> alarm_out.ybit_clear && !alarm_out.ds0_force)
        else $error("Y-bit clear missing");

    chk_fs12_one: assert property (alarm_out.fs12_one
        |-> r_sel == TYG_SEL_J1 && r.mode == TYG_MODE_SF)
        else $error("Fs frame 12 alarm in wrong setting");

    chk_pattern_half: assert property (alarm_out.dl_valid && r_sel == TYG_SEL_STD
        |-> alarm_out.dl_bit == (r.idx < TYG_PAT_HALF))
        else $error("ESF pattern bit wrong");

    chk_j1_ones: assert property (alarm_out.dl_valid && r_sel == TYG_SEL_J1ESF
        |-> alarm_out.dl_bit)
        else $error("J1 ESF pattern not all ones");

    chk_burst_short: assert property (r.fsm == TYG_SEND && burst && !r_ctl && enable
        && pat_done && r.count < 8'hFE |=> r.fsm == TYG_SEND)
        else $error("burst ended before 255 patterns");

    chk_held_alive: assert property (r.fsm == TYG_SEND && enable && esf
        && n.agc[TYG_CTL_BIT] && !ctl_rise |=> r.fsm == TYG_SEND)
        else $error("alarm stopped while duration bit held");

    chk_extend_count: assert property (ctl_rises_in_send |=> r.count == 8'h00)
        else $error("new pulse did not restart counter");

    chk_gap_quiet: assert property (alarm_ends |-> quiet_8)
        else $error("new alarm inside the gap");

    chk_gap_state: assert property (r.fsm == TYG_GAP |-> !alarm_out.active
        && n.fsm != TYG_SEND)
        else $error("alarm during gap");

    chk_count_step: assert property (r.fsm == TYG_SEND && esf && enable && pat_done
        && !ctl_rise && r.count < TYG_PATTERNS |=> r.count == $past(r.count) + 8'h01)
        else $error("pattern counter did not step");

    chk_count_hold: assert property (r.fsm == TYG_SEND && !pat_done && !ctl_rise
        |=> r.count == $past(r.count))
        else $error("pattern counter moved mid pattern");

    chk_level_stop: assert property (r.fsm == TYG_SEND && !esf && enable
        && !n.agc[TYG_CTL_BIT] |=> r.fsm == TYG_GAP)
        else $error("level alarm did not stop");

    chk_bus_ready: assert property (apb_in.psel && apb_in.penable && !apb_out.pready
        |=> apb_out.pready)
        else $error("APB access not answered");

    chk_rsp_single: assert property (apb_out.pready
        |=> !apb_out.pready)
        else $error("pready held longer than one cycle");

    chk_err_data: assert property (apb_out.pslverr
        |-> apb_out.pready && apb_out.prdata == 32'h0000_0000)
        else $error("error response with data");

    chk_agc_write: assert property (apb_in.psel && apb_in.penable && apb_in.pwrite
        && apb_out.pready && apb_in.paddr == TYG_AGC_ADDR |=> r.agc == $past(apb_in.pwdata[7:0]))
        else $error("control write did not land");

    chk_start_gate: assert property ($rose(alarm_out.active)
        |-> r_enf && r_sel != TYG_SEL_OFF)
        else $error("alarm started while disabled");

    chk_start_clear: assert property ($rose(alarm_out.active)
        |-> r.count == 8'h00 && r.idx == 4'h0)
        else $error("alarm started with stale counters");

    chk_disable_stop: assert property (r.fsm == TYG_SEND && !enable
        |=> r.fsm == TYG_GAP)
        else $error("alarm kept running while disabled");

    chk_dl_mode: assert property (alarm_out.dl_valid
        |-> alarm_out.active && r.mode == TYG_MODE_ESF)
        else $error("data link taken outside ESF alarm");

    chk_dl_owned: assert property (alarm_out.active && r.mode == TYG_MODE_ESF
        |-> alarm_out.dl_valid)
        else $error("ESF alarm without data link");

    chk_ds0_mode: assert property (alarm_out.ds0_force
        |-> alarm_out.active && (r.mode == TYG_MODE_SF || r.mode == TYG_MODE_N))
        else $error("DS0 force in wrong mode");

    chk_ds0_sel: assert property (alarm_out.ds0_force
        |-> r_sel == TYG_SEL_STD || r_sel == TYG_SEL_J1ESF)
        else $error("DS0 force with wrong select");

    chk_ybit_mode: assert property (alarm_out.ybit_clear
        |-> alarm_out.active && r.mode == TYG_MODE_T1DM)
        else $error("Y-bit clear in wrong mode");

    chk_j1_sf: assert property (alarm_out.active && r_sel == TYG_SEL_J1
        && r.mode == TYG_MODE_SF |-> alarm_out.fs12_one && !alarm_out.ds0_force)
        else $error("J1 SF alarm format wrong");

    chk_sel11_n: assert property (alarm_out.active && r_sel == TYG_SEL_J1ESF
        && r.mode == TYG_MODE_N |-> alarm_out.ds0_force)
        else $error("select 11 in N mode lacks DS0 force");

    chk_idx_step: assert property (r.fsm == TYG_SEND && esf && enable && dl_bit_req_in
        |=> r.idx == $past(r.idx) + 4'h1)
        else $error("slot index did not step");

    chk_idx_hold: assert property (r.fsm == TYG_SEND && !dl_bit_req_in
        |=> r.idx == $past(r.idx))
        else $error("slot index moved without a slot");

    chk_mid_pattern: assert property (pattern_mid
        |=> r.fsm == TYG_SEND)
        else $error("ESF alarm cut inside a pattern");

    chk_burst_end: assert property (pattern_end
        ##0 (burst && !n.agc[TYG_CTL_BIT] && r.count == 8'hFE) |=> r.fsm == TYG_GAP)
        else $error("burst did not end at 255 patterns");

    chk_follow_end: assert property (pattern_end
        ##0 (!burst && !n.agc[TYG_CTL_BIT]) |=> r.fsm == TYG_GAP)
        else $error("follow alarm did not end");

    chk_count_sat: assert property (r.fsm == TYG_SEND && r.count == TYG_PATTERNS
        && !ctl_rise |=> r.count == TYG_PATTERNS)
        else $error("pattern counter left saturation");

    chk_gap_entry: assert property ($fell(alarm_out.active)
        |-> r.fsm == TYG_GAP && r.gap_cnt == '0)
        else $error("alarm end did not start the gap");

    chk_gap_hold: assert property (r.fsm == TYG_GAP && r.gap_cnt < GAP_LAST
        |=> r.fsm == TYG_GAP)
        else $error("gap ended early");

    chk_gap_exit: assert property (r.fsm == TYG_GAP && r.gap_cnt >= GAP_LAST
        |=> r.fsm == TYG_IDLE)
        else $error("gap did not end");

    chk_gap_pend: assert property (r.fsm == TYG_GAP && ctl_rise
        |=> r.pend)
        else $error("request in gap was lost");
endmodule : tyg_yellow_gen

//--- tyg_pkg.sv
// Constants, types and register map for the yellow alarm one-second generator
package tyg_pkg;
    localparam logic [11:0] TYG_AGC_ADDR = 12'h108;
    localparam logic [11:0] TYG_STAT_ADDR = 12'h10C;
    localparam logic [11:0] TYG_MODE_ADDR = 12'h110;
    localparam int TYG_ENF_BIT = 7;
    localparam int TYG_CTL_BIT = 6;
    localparam int TYG_SEL_LSB = 4;
    localparam logic [7:0] TYG_AGC_RESET = 8'h00;
    localparam logic [1:0] TYG_MODE_RESET = 2'h0;
    localparam logic [7:0] TYG_PATTERNS = 8'hFF;
    localparam logic [3:0] TYG_PAT_LAST = 4'hF;
    localparam logic [3:0] TYG_PAT_HALF = 4'h8;
    localparam int TYG_CLK_MHZ = 200;
    localparam int TYG_GAP_TIME_MS = 1000;
    localparam int TYG_GAP_CYCLES = TYG_GAP_TIME_MS * 1000 * TYG_CLK_MHZ;
    localparam int TYG_GAP_W = 28;

    typedef enum logic [1:0] {
        TYG_MODE_SF = 2'h0,
        TYG_MODE_N = 2'h1,
        TYG_MODE_T1DM = 2'h2,
        TYG_MODE_ESF = 2'h3
    } tyg_mode_t;

    typedef enum logic [1:0] {
        TYG_SEL_OFF = 2'h0,
        TYG_SEL_STD = 2'h1,
        TYG_SEL_J1 = 2'h2,
        TYG_SEL_J1ESF = 2'h3
    } tyg_sel_t;

    typedef enum logic [2:0] {
        TYG_IDLE = 3'h1,
        TYG_SEND = 3'h2,
        TYG_GAP = 3'h4
    } tyg_fsm_t;

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } tyg_apb_req_t;

    typedef struct packed {
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } tyg_apb_rsp_t;

    typedef struct packed {
        logic ds0_force;
        logic ybit_clear;
        logic fs12_one;
        logic dl_valid;
        logic dl_bit;
        logic active;
    } tyg_alarm_t;

    typedef struct packed {
        logic [7:0] agc;
        logic [1:0] mode;
        tyg_fsm_t fsm;
        logic pend;
        logic [7:0] count;
        logic [3:0] idx;
        logic [TYG_GAP_W-1:0] gap_cnt;
        tyg_apb_rsp_t rsp;
        tyg_alarm_t alarm;
    } tyg_state_t;
endpackage : tyg_pkg

//--- tyg_far_end.sv
// Far-end framer model: paces data link slots and tallies alarm bits
`timescale 1ns/10ps
module tyg_far_end
    import tyg_pkg::*;
(
    input wire logic clk_sys_in,
    input wire logic rstn_in,
    input wire logic slow_in,
    input wire logic clr_in,
    input wire logic ones_in,
    input wire tyg_alarm_t alarm_in,
    output logic dl_bit_req_out,
    output int n_slots_out,
    output int n_bad_out
);
    logic [2:0] div;
    logic want;
    // Each pattern is eight ones then eight zeros, or sixteen ones
    assign want = ones_in || (n_slots_out % 16 < 8);
    always @(posedge clk_sys_in or negedge rstn_in) begin
        if (!rstn_in) begin
            div <= 3'h0;
            dl_bit_req_out <= 1'b0;
            n_slots_out <= 0;
            n_bad_out <= 0;
        end else begin
            div <= div + 3'h1;
            // Slow pacing asks for a slot every eighth cycle, fast every second
            dl_bit_req_out <= slow_in ? (div == 3'h0) : !div[0];
            if (clr_in) begin
                n_slots_out <= 0;
                n_bad_out <= 0;
            end else if (dl_bit_req_out && alarm_in.dl_valid) begin
                n_slots_out <= n_slots_out + 1;
                n_bad_out <= n_bad_out + int'(alarm_in.dl_bit !== want);
            end
        end
    end
endmodule : tyg_far_end

//--- test_t1_yellow_alarm_one_second_gen.sv
// Self-checking bench for the yellow alarm generator over APB
`timescale 1ns/10ps
`define CHK(a, e) chk_val(32'(a), 32'(e))
module test_t1_yellow_alarm_one_second_gen;
    import tyg_pkg::*;
    localparam int GAP = 20;
    localparam int BURST = 255 * 16;
    localparam logic [11:0] AGC = TYG_AGC_ADDR;
    // Entry: {enforce, mode}, select, {ds0, ybit, fs12, active}
    localparam logic [11:0] TBL [10] = '{12'h419, 12'h519, 12'h615, 12'h423, 12'h625,
        12'h439, 12'h539, 12'h635, 12'h400, 12'h010};
    logic clk_sys_in, rstn_in, slow, clr, ones, req;
    logic [31:0] rdata;
    tyg_apb_req_t apb;
    tyg_apb_rsp_t rsp;
    tyg_alarm_t alarm;
    int n_slots, n_bad, t0;
    int miscompares = 0;
    int n_tests = 0;
    int cyc = 0;
    tyg_yellow_gen #(.GAP_CYCLES(GAP)) dut (.clk_sys_in(clk_sys_in), .rstn_in(rstn_in),
        .apb_in(apb), .apb_out(rsp), .dl_bit_req_in(req), .alarm_out(alarm));
    tyg_far_end far (.clk_sys_in(clk_sys_in), .rstn_in(rstn_in), .slow_in(slow),
        .clr_in(clr), .ones_in(ones), .alarm_in(alarm), .dl_bit_req_out(req),
        .n_slots_out(n_slots), .n_bad_out(n_bad));
    task automatic chk_val(input logic [31:0] a, input logic [31:0] e);
        n_tests++;
        if (a !== e) begin
            miscompares++;
            $display("wrong value at %0t: got %h expected %h", $time, a, e);
        end
    endtask : chk_val
    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys_in);
    endtask : tick
    // Request is held until pready is seen, then the bus idles one cycle
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d, input logic e);
        int t;
        t = 0;
        apb <= '{1'b1, 1'b0, w, a, d};
        tick(1);
        apb.penable <= 1'b1;
        do begin
            tick(1);
            t++;
        end while (rsp.pready !== 1'b1 && t < 50);
        rdata = rsp.prdata;
        `CHK({rsp.pready, rsp.pslverr}, {1'b1, e});
        apb.psel <= 1'b0;
        apb.penable <= 1'b0;
        tick(1);
    endtask : xfer
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        xfer(1'b1, a, d, 1'b0);
    endtask : wr
    function automatic logic [31:0] ctlw(input logic en, input logic go, input logic [1:0] s);
        return {24'h000000, en, go, s, 4'h0};
    endfunction : ctlw
    task automatic wait_act(input logic v, input int lim);
        for (int t = 0; t < lim && alarm.active !== v; t++) begin
            tick(1);
        end
        `CHK(alarm.active, v);
    endtask : wait_act
    // Short request pulse, optionally pulsed again after mid cycles
    task automatic burst(input logic [1:0] s, input int mid, input int lim);
        tick(GAP + 4);
        clr <= 1'b1;
        tick(1);
        clr <= 1'b0;
        wr(AGC, ctlw(1'b1, 1'b1, s));
        wr(AGC, ctlw(1'b1, 1'b0, s));
        if (mid > 0) begin
            tick(mid);
            wr(AGC, ctlw(1'b1, 1'b1, s));
            wr(AGC, ctlw(1'b1, 1'b0, s));
        end
        wait_act(1'b0, lim);
        t0 = cyc;
    endtask : burst
    task automatic finish_test();
        $display("comparisons %0d, mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : finish_test
    initial begin
        clk_sys_in = 1'b0;
        forever #2.5 clk_sys_in = ~clk_sys_in;
    end
    // The tests need about 65000 cycles
    always @(posedge clk_sys_in) begin
        cyc <= cyc + 1;
        if (cyc == 90000) begin
            miscompares++;
            finish_test();
        end
    end
    initial begin
        apb = '0;
        rstn_in = 1'b0;
        slow = 1'b0;
        clr = 1'b0;
        ones = 1'b0;
        tick(20);
        rstn_in <= 1'b1;
        tick(1);
        xfer(1'b0, AGC, 32'h0, 1'b0);
        `CHK(rdata, 32'h0);
        wr(AGC, 32'h0000008F);
        xfer(1'b1, 12'h200, 32'h000000FF, 1'b1);
        xfer(1'b0, AGC, 32'h0, 1'b0);
        `CHK(rdata, 32'h0000008F);
        xfer(1'b0, 12'h200, 32'h0, 1'b1);
        `CHK(rdata, 32'h0);
        xfer(1'b0, TYG_STAT_ADDR, 32'h0, 1'b0);
        `CHK(rdata, 32'h1);
        xfer(1'b0, TYG_MODE_ADDR, 32'h0, 1'b0);
        `CHK(rdata, 32'h0);
        $display("test registers done");
        for (int i = 0; i < 10; i++) begin
            wr(TYG_MODE_ADDR, 32'(TBL[i][9:8]));
            wr(AGC, ctlw(TBL[i][10], 1'b1, TBL[i][5:4]));
            tick(1);
            `CHK({alarm[5:3], alarm[0]}, TBL[i][3:0]);
            wr(AGC, ctlw(TBL[i][10], 1'b0, TBL[i][5:4]));
            tick(1);
            `CHK(alarm.active, 1'b0);
            tick(GAP + 4);
        end
        $display("test framed formats done");
        wr(TYG_MODE_ADDR, 32'h3);
        burst(2'h1, 0, BURST * 2 + 100);
        `CHK(n_slots, BURST);
        `CHK(n_bad, 0);
        wr(AGC, ctlw(1'b1, 1'b1, 2'h1));
        tick(1);
        `CHK(alarm.active, 1'b0);
        xfer(1'b0, TYG_STAT_ADDR, 32'h0, 1'b0);
        `CHK(rdata, 32'h0000FF0C);
        wait_act(1'b1, GAP + 8);
        `CHK(cyc - t0 >= GAP, 1'b1);
        tick(BURST * 2 + 200);
        `CHK(alarm.active, 1'b1);
        wr(AGC, ctlw(1'b1, 1'b0, 2'h1));
        wait_act(1'b0, 40);
        $display("test esf burst and gap done");
        burst(2'h1, BURST, BURST * 3 + 100);
        `CHK(n_slots >= BURST * 3 / 2 - 24 && n_slots <= BURST * 3 / 2 + 48, 1'b1);
        ones <= 1'b1;
        slow <= 1'b1;
        burst(2'h3, 0, BURST * 8 + 100);
        `CHK(n_slots, BURST);
        `CHK(n_bad, 0);
        $display("test esf restart and sixteen ones done");
        ones <= 1'b0;
        slow <= 1'b0;
        tick(GAP + 4);
        wr(AGC, ctlw(1'b1, 1'b1, 2'h2));
        tick(200);
        `CHK(alarm.active, 1'b1);
        wr(AGC, ctlw(1'b1, 1'b0, 2'h2));
        wait_act(1'b0, 40);
        `CHK(n_bad, 0);
        $display("test esf follow done");
        finish_test();
    end
endmodule : test_t1_yellow_alarm_one_second_gen
